// *** rtl/alu_pkg.sv ***
// Functional notes
// - add immediate to accumulator, flags C DC Z
// - add file to accumulator, destination select
// - destination bit 0 accumulator, 1 file
// - and file with accumulator, zero flag only
// - and immediate with accumulator, zero only
// - clear chosen file bit, flags untouched
// - set chosen file bit, flags untouched
// - skip next when tested bit is zero
// - skip next when tested bit is one
package alu_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int BIT_W = 3;
   localparam int NIB_W = 4;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;
   localparam logic [DATA_W-1:0] BIT_ONE = 8'h01;
   localparam logic FLAG_RESET = 1'b0;

   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_ADD_IMM = 4'h1,
      OP_ADD_FILE = 4'h2,
      OP_AND_FILE = 4'h3,
      OP_AND_IMM = 4'h4,
      OP_BIT_CLEAR = 4'h5,
      OP_BIT_SET = 4'h6,
      OP_SKIP_ZERO = 4'h7,
      OP_SKIP_ONE = 4'h8
   } op_t;

   typedef enum logic [0:0] {
      ST_RUN = 1'b0,
      ST_SKIP = 1'b1
   } exec_state_t;
endpackage

// *** rtl/adder_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface adder_if;
   import alu_pkg::*;
   logic [DATA_W-1:0] a;
   logic [DATA_W-1:0] b;
   logic [DATA_W-1:0] sum;
   logic carry;
   logic half_carry;
   logic zero;
   modport user (output a, output b, input sum, input carry, input half_carry, input zero);
   modport unit (input a, input b, output sum, output carry, output half_carry, output zero);
endinterface
`default_nettype wire

// *** rtl/flag_adder.sv ***
`timescale 1ns/100ps
`default_nettype none
module flag_adder
   import alu_pkg::*;
(
   adder_if.unit bus
);
   logic [NIB_W:0] low_sum;
   logic [DATA_W:0] full_sum;
   assign low_sum = {1'b0, bus.a[NIB_W-1:0]} + {1'b0, bus.b[NIB_W-1:0]};
   assign full_sum = {1'b0, bus.a} + {1'b0, bus.b};
   assign bus.sum = full_sum[DATA_W-1:0];
   assign bus.carry = full_sum[DATA_W];
   assign bus.half_carry = low_sum[NIB_W];
   assign bus.zero = (full_sum[DATA_W-1:0] == '0);
endmodule
`default_nettype wire

// *** rtl/add_and_bit_test_execution.sv ***
`timescale 1ns/100ps
`default_nettype none
module add_and_bit_test_execution
   import alu_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // decoded instruction
   input wire logic instr_valid,
   input wire op_t instr_op,
   input wire logic [DATA_W-1:0] instr_imm,
   input wire logic [ADDR_W-1:0] instr_addr,
   input wire logic [BIT_W-1:0] instr_bit,
   input wire logic instr_dest,
   // file register space
   output logic [ADDR_W-1:0] file_addr,
   input wire logic [DATA_W-1:0] file_rdata,
   output logic file_we,
   output logic [DATA_W-1:0] file_wdata,
   // accumulator and flags
   output logic [DATA_W-1:0] acc_q,
   output logic carry_q,
   output logic half_carry_flag_q,
   output logic zero_q,
   // skip control
   output logic skip_q,
   output logic busy
);
   // one adder serves both add forms; the and path needs no carry chain
   adder_if add_bus ();
   flag_adder u_add (
      .bus(add_bus)
   );

   // sequencer state: run, or the discarded slot after a skip hit
   exec_state_t state_q;
   exec_state_t state_d;

   // decoded operation strobes, each already qualified by live
   logic live;
   logic op_add_imm;
   logic op_add_file;
   logic op_and_file;
   logic op_and_imm;
   logic op_bit_clear;
   logic op_bit_set;
   logic op_skip_zero;
   logic op_skip_one;
   logic is_add;
   logic is_and;
   logic is_bit_write;

   // operands and results
   logic [DATA_W-1:0] operand;
   logic [DATA_W-1:0] bit_mask;
   logic [DATA_W-1:0] and_res;
   logic [DATA_W-1:0] result;
   logic [DATA_W-1:0] bit_res;
   logic tested_bit;
   logic to_acc;
   logic to_file;
   logic skip_hit;

   // next values of the registered outputs
   logic [DATA_W-1:0] acc_d;
   logic skip_d;
   logic carry_d;
   logic half_carry_d;
   logic zero_d;

   // one-hot mask for a bit position
   function automatic logic [DATA_W-1:0] bit_select(input logic [BIT_W-1:0] pos);
      return BIT_ONE << pos;
   endfunction

   function automatic logic bit_pick(input logic [DATA_W-1:0] data, input logic [BIT_W-1:0] pos);
      return data[pos];
   endfunction

   // literal forms take the immediate and always land in the accumulator
   function automatic logic uses_imm(input op_t op);
      return (op == OP_ADD_IMM) || (op == OP_AND_IMM);
   endfunction

   // only the file forms honour the destination bit
   function automatic logic uses_dest(input op_t op);
      return (op == OP_ADD_FILE) || (op == OP_AND_FILE);
   endfunction

   function automatic logic is_zero(input logic [DATA_W-1:0] data);
      return data == '0;
   endfunction

   // a decoded strobe only fires outside the discarded slot
   function automatic logic op_hit(input logic ok, input op_t op, input op_t want);
      return ok && (op == want);
   endfunction

   // an instruction offered during the skip slot is dropped, not delayed
   assign busy = (state_q == ST_SKIP);
   assign live = instr_valid && !busy;

   // one strobe per operation keeps the routing terms readable
   assign op_add_imm = op_hit(live, instr_op, OP_ADD_IMM);
   assign op_add_file = op_hit(live, instr_op, OP_ADD_FILE);
   assign op_and_file = op_hit(live, instr_op, OP_AND_FILE);
   assign op_and_imm = op_hit(live, instr_op, OP_AND_IMM);
   assign op_bit_clear = op_hit(live, instr_op, OP_BIT_CLEAR);
   assign op_bit_set = op_hit(live, instr_op, OP_BIT_SET);
   assign op_skip_zero = op_hit(live, instr_op, OP_SKIP_ZERO);
   assign op_skip_one = op_hit(live, instr_op, OP_SKIP_ONE);
   assign is_add = op_add_imm || op_add_file;
   assign is_and = op_and_imm || op_and_file;
   assign is_bit_write = op_bit_clear || op_bit_set;

   // file address is combinational so file_rdata is valid the same cycle
   assign file_addr = instr_addr;
   assign bit_mask = bit_select(instr_bit);
   assign tested_bit = bit_pick(file_rdata, instr_bit);

   // the and path and the adder see the same operand
   assign operand = uses_imm(instr_op) ? instr_imm : file_rdata;
   assign add_bus.a = acc_q;
   assign add_bus.b = operand;
   assign and_res = acc_q & operand;
   assign result = is_add ? add_bus.sum : and_res;
   assign bit_res = op_bit_set ? (file_rdata | bit_mask) : (file_rdata & ~bit_mask);

   // literal forms ignore the destination bit
   assign to_acc = (is_add || is_and) && (uses_imm(instr_op) || instr_dest == DEST_ACC);
   assign to_file = (is_add || is_and) && uses_dest(instr_op) && instr_dest == DEST_FILE;
   assign skip_hit = (op_skip_zero && !tested_bit) || (op_skip_one && tested_bit);

   // write-back is combinational; the file space takes it on the same edge, so a
   // following instruction already reads the new value
   assign file_we = to_file || is_bit_write;
   assign file_wdata = to_file ? result : bit_res;

   assign acc_d = to_acc ? result : acc_q;
   assign skip_d = skip_hit;

   // bit ops and skips leave every flag alone; and keeps carry and half carry
   always_comb begin
      carry_d = carry_q;
      half_carry_d = half_carry_flag_q;
      zero_d = zero_q;
      if (is_add) begin
         carry_d = add_bus.carry;
         half_carry_d = add_bus.half_carry;
         zero_d = add_bus.zero;
      end else if (is_and) begin
         zero_d = is_zero(and_res);
      end
   end

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_RUN: begin
            state_d = skip_hit ? ST_SKIP : ST_RUN;
         end
         ST_SKIP: begin
            // the substituted no-operation is this single slot
            state_d = ST_RUN;
         end
      endcase
   end

   // a skip hit costs exactly one extra slot
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // skip_q marks the discarded slot, one cycle after the decision
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         skip_q <= FLAG_RESET;
      end else begin
         skip_q <= skip_d;
      end
   end

   // accumulator holds unless a result is routed to it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= ACC_RESET;
      end else begin
         acc_q <= acc_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         carry_q <= FLAG_RESET;
      end else begin
         carry_q <= carry_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         half_carry_flag_q <= FLAG_RESET;
      end else begin
         half_carry_flag_q <= half_carry_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         zero_q <= FLAG_RESET;
      end else begin
         zero_q <= zero_d;
      end
   end
endmodule
`default_nettype wire

// *** sim/alu_exec_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module alu_exec_sva import alu_pkg::*; (
   input wire logic ref_clk, rst_n, instr_valid, instr_dest, file_we, carry_q, half_carry_flag_q, zero_q, busy,
   input wire op_t instr_op,
   input wire logic [7:0] instr_imm, file_rdata, file_wdata, acc_q,
   input wire logic [2:0] instr_bit);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire [15:0] h = 16'(instr_valid & ~busy) << instr_op;
   wire [7:0] m = 8'h01 << instr_bit;
   wire [8:0] s = acc_q + instr_imm;
   wire n = acc_q[3:0] + instr_imm[3:0] > 5'h0f;
   wire t = |(file_rdata & m);
   wire [7:0] a = acc_q & file_rdata;
   wire [7:0] b = acc_q & instr_imm;
   wire [7:0] f = acc_q + file_rdata;
   wire z = s[7:0] == 8'h00;
   AST_ADD: assert property (h[OP_ADD_IMM] |=> {carry_q, acc_q, half_carry_flag_q} == $past({s, n})) else $error("add");
   AST_DST: assert property (h[OP_ADD_FILE] || h[OP_AND_FILE] |-> file_we == instr_dest) else $error("dst");
   AST_ANF: assert property (h[OP_AND_FILE] |=> zero_q == ($past(a) == 8'h00)) else $error("anf");
   AST_ANI: assert property (h[OP_AND_IMM] |=> acc_q == $past(b) && $stable(carry_q)) else $error("ani");
   AST_CLR: assert property (h[OP_BIT_CLEAR] |-> file_we && file_wdata == (file_rdata & ~m)) else $error("clr");
   AST_SET: assert property (h[OP_BIT_SET] |-> file_wdata == (file_rdata | m) ##1 $stable(zero_q)) else $error("set");
   AST_SKZ: assert property (h[OP_SKIP_ZERO] |=> busy == !$past(t)) else $error("skz");
   AST_SKO: assert property (h[OP_SKIP_ONE] |=> busy == $past(t)) else $error("sko");
   AST_ADF: assert property (h[OP_ADD_FILE] && !instr_dest |=> acc_q == $past(f)) else $error("adf");
   AST_ZER: assert property (h[OP_ADD_IMM] |=> zero_q == $past(z)) else $error("zer");
   cover property (busy);
   cover property (h[OP_ADD_FILE] && instr_dest);
   cover property (carry_q && half_carry_flag_q);
endmodule
`default_nettype wire

// *** sim/file_space_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module file_space_model (
   input wire logic ref_clk, file_we,
   input wire logic [6:0] file_addr,
   input wire logic [7:0] file_wdata,
   output logic [7:0] file_rdata);
   logic [7:0] mem_q [128];
   initial foreach (mem_q[i]) mem_q[i] = 8'(i);
   assign file_rdata = mem_q[file_addr];
   always @(posedge ref_clk) if (file_we) mem_q[file_addr] <= file_wdata;
endmodule
`default_nettype wire

// *** sim/add_and_bit_test_execution_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module add_and_bit_test_execution_tb import alu_pkg::*;;
   logic ref_clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, instr_dest = 1'b0;
   logic file_we, carry_q, half_carry_flag_q, zero_q, skip_q, busy;
   op_t instr_op = OP_NONE;
   logic [7:0] instr_imm = 8'h00, acc_q, file_rdata, file_wdata;
   logic [6:0] file_addr;
   logic [2:0] instr_bit = 3'h0;
   int n_fail = 0, cmp_count = 0, cyc = 0;
   // address rides on the immediate field to keep the driver short
   wire [6:0] instr_addr = instr_imm[6:0];
   add_and_bit_test_execution DUT (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .instr_valid(instr_valid),
      .instr_op(instr_op),
      .instr_imm(instr_imm),
      .instr_addr(instr_addr),
      .instr_bit(instr_bit),
      .instr_dest(instr_dest),
      .file_addr(file_addr),
      .file_rdata(file_rdata),
      .file_we(file_we),
      .file_wdata(file_wdata),
      .acc_q(acc_q),
      .carry_q(carry_q),
      .half_carry_flag_q(half_carry_flag_q),
      .zero_q(zero_q),
      .skip_q(skip_q),
      .busy(busy)
   );
   file_space_model u_mem (
      .ref_clk(ref_clk),
      .file_we(file_we),
      .file_addr(file_addr),
      .file_wdata(file_wdata),
      .file_rdata(file_rdata)
   );
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (++cyc > 400) begin
      n_fail++;
      close_out;
   end
   task chk(string what, logic [7:0] exp, logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task drive(op_t op, logic [7:0] v, logic [2:0] b, logic d);
      instr_op <= op;
      instr_imm <= v;
      instr_bit <= b;
      instr_dest <= d;
      instr_valid <= 1'b1;
   endtask
   task ex(op_t op, logic [7:0] v, logic [2:0] b = 3'h0, logic d = 1'b0);
      drive(op, v, b, d);
      @(posedge ref_clk);
   endtask
   // test, then offer an increment in the slot that a hit must swallow
   task skip_pair(op_t op, logic [7:0] v, logic [2:0] b, logic hit);
      ex(op, v, b);
      drive(OP_ADD_IMM, 8'h01, 3'h0, 1'b0);
      @(negedge ref_clk);
      chk("skip_q", {7'h00, hit}, {7'h00, skip_q});
      chk("busy", {7'h00, hit}, {7'h00, busy});
      @(posedge ref_clk);
   endtask
   task idle;
      instr_valid <= 1'b0;
      @(posedge ref_clk);
   endtask
   task close_out;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task t_alu;
      ex(OP_ADD_IMM, 8'hf8);
      ex(OP_ADD_IMM, 8'h0c);
      idle;
      chk("acc", 8'h04, acc_q);
      chk("flags", 8'h06, {5'h00, carry_q, half_carry_flag_q, zero_q});
      ex(OP_AND_IMM, 8'h0b);
      ex(OP_ADD_FILE, 8'h7f, 3'h0, 1'b1);
      ex(OP_ADD_FILE, 8'h29);
      ex(OP_AND_FILE, 8'h7f, 3'h0, 1'b1);
      ex(OP_AND_FILE, 8'h16);
      idle;
      chk("file", 8'h29, u_mem.mem_q[127]);
      chk("acc", 8'h00, acc_q);
      chk("flags", 8'h01, {5'h00, carry_q, half_carry_flag_q, zero_q});
      $display("alu test done");
   endtask
   task t_bit;
      ex(OP_BIT_SET, 8'h00, 3'h7);
      ex(OP_BIT_CLEAR, 8'h03);
      skip_pair(OP_SKIP_ZERO, 8'h03, 3'h0, 1'b1);
      skip_pair(OP_SKIP_ONE, 8'h00, 3'h7, 1'b1);
      skip_pair(OP_SKIP_ZERO, 8'h00, 3'h7, 1'b0);
      skip_pair(OP_SKIP_ONE, 8'h03, 3'h0, 1'b0);
      idle;
      chk("file", 8'h80, u_mem.mem_q[0]);
      chk("file", 8'h02, u_mem.mem_q[3]);
      chk("acc", 8'h02, acc_q);
      $display("bit test done");
   endtask
   // a mid-run reset must bring the accumulator and flags back to zero
   task t_reset;
      rst_n <= 1'b0;
      @(negedge ref_clk);
      chk("acc", 8'h00, acc_q);
      chk("flags", 8'h00, {5'h00, carry_q, half_carry_flag_q, zero_q});
      @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      $display("reset test done");
   endtask
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_alu;
      t_bit;
      t_reset;
      close_out;
   end
endmodule
bind add_and_bit_test_execution alu_exec_sva u_sva (.*);
`default_nettype wire
